// ==== hdl/tec_pkg.sv ====
// package: register map, field layout, reset values and types of the timer/event counter
package tec_pkg;
   localparam int TEC_CNT_W = 16;
   localparam int TEC_ADDR_W = 16;
   localparam int TEC_DATA_W = 8;

   // register offsets
   localparam logic [15:0] TEC_OFS_MODE = 16'hff60;
   localparam logic [15:0] TEC_OFS_PRESC = 16'hff61;
   localparam logic [15:0] TEC_OFS_CCCTL = 16'hff62;
   localparam logic [15:0] TEC_OFS_OUTCTL = 16'hff63;
   localparam logic [15:0] TEC_OFS_REGA_LO = 16'hff64;
   localparam logic [15:0] TEC_OFS_REGA_HI = 16'hff65;
   localparam logic [15:0] TEC_OFS_REGB_LO = 16'hff66;
   localparam logic [15:0] TEC_OFS_REGB_HI = 16'hff67;
   localparam logic [15:0] TEC_OFS_CNT_LO = 16'hff68;
   localparam logic [15:0] TEC_OFS_CNT_HI = 16'hff69;

   // reset values and counter maximum
   localparam logic [7:0] TEC_RST_CTRL = 8'h00;
   localparam logic [15:0] TEC_RST_CNT = 16'h0000;
   localparam logic [15:0] TEC_CNT_MAX = 16'hffff;

   // timer_mode_control fields
   localparam int TEC_MODE_OVF_BIT = 0;
   localparam int TEC_MODE_LO_BIT = 2;
   localparam int TEC_MODE_HI_BIT = 3;
   // capture_compare_control fields
   localparam int TEC_CC_A_ROLE_BIT = 0;
   localparam int TEC_CC_A_TRIG_BIT = 1;
   localparam int TEC_CC_B_ROLE_BIT = 2;
   // timer_output_control fields
   localparam int TEC_OC_GATE_BIT = 0;
   localparam int TEC_OC_INV_A_BIT = 1;
   localparam int TEC_OC_CLEAR_BIT = 2;
   localparam int TEC_OC_SET_BIT = 3;
   localparam int TEC_OC_INV_B_BIT = 4;
   // prescaler_edge_select fields
   localparam int TEC_PS_CLK_LO_BIT = 0;
   localparam int TEC_PS_CLK_HI_BIT = 1;
   localparam int TEC_PS_E1_LO_BIT = 4;
   localparam int TEC_PS_E1_HI_BIT = 5;
   localparam int TEC_PS_E2_LO_BIT = 6;
   localparam int TEC_PS_E2_HI_BIT = 7;

   // clock dividers of the subsystem clocks
   localparam int TEC_DIV2_W = 4;
   localparam logic [3:0] TEC_DIV16_LAST = 4'hf;
   localparam logic [1:0] TEC_REF_LAST = 2'h3;

   typedef enum logic [1:0] {
      TEC_MODE_STOP,
      TEC_MODE_FREE,
      TEC_MODE_EDGE_CLR,
      TEC_MODE_MATCH_CLR
   } tec_mode_t;

   typedef enum logic [1:0] {
      TEC_SRC_CLK1,
      TEC_SRC_CLK1_DIV2,
      TEC_SRC_CLK2_DIV16,
      TEC_SRC_EXT_EDGE
   } tec_src_t;

   typedef enum logic [1:0] {
      TEC_EDGE_FALL,
      TEC_EDGE_RISE,
      TEC_EDGE_BAD,
      TEC_EDGE_BOTH
   } tec_edge_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } tec_bus_req_t;

   typedef struct packed {
      logic rise;
      logic fall;
   } tec_edges_t;
endpackage : tec_pkg

// ==== hdl/tec_edge_filter.sv ====
// edge input: two-flop synchroniser, double-sample noise filter, edge detector
`timescale 1ns/1ps
module tec_edge_filter
   import tec_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic pin_i,
   input wire logic sample_i,
   input wire logic enable_i,
   input wire logic track_i,
   output tec_edges_t edges_o
);
   logic sync1_q;
   logic sync2_q;
   logic samp_q;
   logic level_q;
   logic stable;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else if (ce_i) begin
         sync1_q <= pin_i;
         sync2_q <= sync1_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_q <= 1'b0;
      end else if (ce_i && sample_i) begin
         samp_q <= sync2_q;
      end
   end

   // level accepted only when seen on two samples in a row
   assign stable = sample_i && (sync2_q == samp_q);

   // level starts at 0: a high pin yields a rise on first enable; stopped later, it follows
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         level_q <= 1'b0;
      end else if (ce_i) begin
         if (enable_i && stable) begin
            level_q <= sync2_q;
         end else if (!enable_i && track_i) begin
            level_q <= sync2_q; // [RULE_22]
         end
      end
   end

   assign edges_o.rise = ce_i && enable_i && stable && sync2_q && !level_q; // [RULE_22]
   assign edges_o.fall = ce_i && enable_i && stable && !sync2_q && level_q;
endmodule : tec_edge_filter

// ==== hdl/tec_timer_ctrl.sv ====
// 16-bit timer/event counter: control registers, counter, capture/compare, output flip-flop
//
// Overview of operation
// [RULE_01] reset clears mode, capture/compare, output and prescaler registers to zero
// [RULE_02] mode field: stop and hold zero, free run, edge restart, match-A restart
// [RULE_03] counting starts once mode is nonzero; software stops it by writing zero
// [RULE_04] stopped: output and match interrupts idle; running: matches update both
// [RULE_05] mode bit 0 is the overflow flag, set on counter overflow
// [RULE_06] software writes mode bits other than overflow only while stopped
// [RULE_07] match-A restart with A at ffff: wrap to zero sets overflow
// [RULE_08] capture/compare bit 2: register B compare when 0, capture when 1
// [RULE_09] bit 1: A captures on second input edge, or first input opposite phase
// [RULE_10] capture/compare bit 0: register A compare when 0, capture when 1
// [RULE_11] software writes capture/compare, output and prescaler only while stopped
// [RULE_12] software never makes A a capture register in match-A restart mode
// [RULE_13] first input on both edges: no opposite-phase capture into A
// [RULE_14] capture trigger pulses last at least two count clock periods
// [RULE_15] output bits 4 and 1 enable toggling on B and A matches
// [RULE_16] set/clear bits: none, force 0, force 1, illegal; both read 0
// [RULE_17] output bit 0 gates the pin: 0 holds low, 1 passes flip-flop
// [RULE_18] prescaler bits 7:6 and 5:4 pick input edges: fall, rise, illegal, both
// [RULE_19] prescaler bits 1:0: clock one, clock one half, clock two sixteenth, edge
// [RULE_20] external count pulses last at least two internal reference periods
// [RULE_21] with edge counting, first input is no trigger and pin no output; first input still triggers captures and restart, pin still driven
// [RULE_22] high input at reset gives a rise on first enable, not after stop
// [RULE_23] counter increments on each rising edge of the count clock
// [RULE_24] counter clears on restart edge or match in the restart modes
// [RULE_25] illegal edge code means that input has no valid edge at all
`timescale 1ns/1ps
module tec_timer_ctrl
   import tec_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire tec_bus_req_t bus_req_i,
   output logic [7:0] bus_rdata_o,
   input wire logic subsystem_clock_one_i,
   input wire logic subsystem_clock_two_i,
   input wire logic first_edge_input_i,
   input wire logic second_edge_input_i,
   output logic timer_output_pin_o,
   output logic match_a_interrupt_o,
   output logic match_b_interrupt_o
);
   // valid edge per selection; the illegal code yields none
   function automatic logic edge_hit(input tec_edge_t sel, input tec_edges_t e);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         TEC_EDGE_FALL: hit = e.fall;
         TEC_EDGE_RISE: hit = e.rise;
         TEC_EDGE_BAD: hit = 1'b0; // [RULE_25]
         TEC_EDGE_BOTH: hit = e.rise | e.fall;
      endcase
      return hit;
   endfunction : edge_hit

   function automatic logic addr_is(input tec_bus_req_t r, input logic [15:0] ofs);
      return r.addr == ofs;
   endfunction : addr_is

   // control registers
   tec_mode_t mode_q;
   logic ovf_q;
   logic [2:0] ccctl_q;
   logic inv_a_q;
   logic inv_b_q;
   logic gate_q;
   tec_edge_t e1_sel_q;
   tec_edge_t e2_sel_q;
   tec_src_t src_q;
   logic [15:0] reg_a_q;
   logic [15:0] reg_b_q;
   logic [15:0] cnt_q;
   logic flip_q;
   logic ran_q;

   // subsystem clock synchronisers and dividers
   logic clk1_s1_q;
   logic clk1_s2_q;
   logic clk1_s3_q;
   logic clk2_s1_q;
   logic clk2_s2_q;
   logic clk2_s3_q;
   logic div2_q;
   logic [3:0] div16_q;
   logic clk1_rise;
   logic clk2_rise;
   logic ref_tick;
   logic int_tick;
   logic samp_tick;
   logic cnt_tick;

   logic running;
   logic wr;
   logic rd;
   tec_edges_t e1_edges;
   tec_edges_t e2_edges;
   logic e1_valid;
   logic e2_valid;
   logic e1_opposite;
   logic match_a;
   logic match_b;
   logic cap_a;
   logic cap_b;
   logic restart;
   logic wrap;

   assign running = (mode_q != TEC_MODE_STOP);
   assign wr = ce_i && bus_req_i.we;
   assign rd = ce_i && bus_req_i.re;

   // subsystem clocks come from pins: two flops before use
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk1_s1_q <= 1'b0;
         clk1_s2_q <= 1'b0;
         clk1_s3_q <= 1'b0;
         clk2_s1_q <= 1'b0;
         clk2_s2_q <= 1'b0;
         clk2_s3_q <= 1'b0;
      end else if (ce_i) begin
         clk1_s1_q <= subsystem_clock_one_i;
         clk1_s2_q <= clk1_s1_q;
         clk1_s3_q <= clk1_s2_q;
         clk2_s1_q <= subsystem_clock_two_i;
         clk2_s2_q <= clk2_s1_q;
         clk2_s3_q <= clk2_s2_q;
      end
   end

   assign clk1_rise = ce_i && clk1_s2_q && !clk1_s3_q;
   assign clk2_rise = ce_i && clk2_s2_q && !clk2_s3_q;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div2_q <= 1'b0;
      end else if (clk1_rise) begin
         div2_q <= !div2_q;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div16_q <= 4'h0;
      end else if (clk2_rise) begin
         div16_q <= div16_q + 4'h1;
      end
   end

   // internal reference for filtering an external count clock: clock two over four
   assign ref_tick = clk2_rise && (div16_q[1:0] == TEC_REF_LAST);

   always_comb begin
      int_tick = 1'b0;
      unique case (src_q)
         TEC_SRC_CLK1: int_tick = clk1_rise; // [RULE_19]
         TEC_SRC_CLK1_DIV2: int_tick = clk1_rise && div2_q; // [RULE_19]
         TEC_SRC_CLK2_DIV16: int_tick = clk2_rise && (div16_q == TEC_DIV16_LAST); // [RULE_19]
         TEC_SRC_EXT_EDGE: int_tick = 1'b0;
      endcase
   end

   // inputs sampled at the count clock; edge counting samples at the reference
   assign samp_tick = (src_q == TEC_SRC_EXT_EDGE) ? ref_tick : int_tick; // [RULE_20]

   tec_edge_filter u_first_in (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .pin_i(first_edge_input_i),
      .sample_i(samp_tick),
      .enable_i(running),
      .track_i(ran_q),
      .edges_o(e1_edges)
   );

   tec_edge_filter u_second_in (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .pin_i(second_edge_input_i),
      .sample_i(samp_tick),
      .enable_i(running),
      .track_i(ran_q),
      .edges_o(e2_edges)
   );

   assign e1_valid = edge_hit(e1_sel_q, e1_edges); // [RULE_18]
   assign e2_valid = edge_hit(e2_sel_q, e2_edges); // [RULE_18]

   // opposite phase of first input's edge; none when both edges selected
   always_comb begin
      e1_opposite = 1'b0;
      unique case (e1_sel_q)
         TEC_EDGE_FALL: e1_opposite = e1_edges.rise;
         TEC_EDGE_RISE: e1_opposite = e1_edges.fall;
         TEC_EDGE_BAD: e1_opposite = 1'b0; // [RULE_25]
         TEC_EDGE_BOTH: e1_opposite = 1'b0; // [RULE_13]
      endcase
   end

   assign cnt_tick = running && ((src_q == TEC_SRC_EXT_EDGE) ? e1_valid : int_tick); // [RULE_19]

   // matches judged on the tick that leaves the matching count
   assign match_a = cnt_tick && !ccctl_q[TEC_CC_A_ROLE_BIT] && (cnt_q == reg_a_q); // [RULE_10]
   assign match_b = cnt_tick && !ccctl_q[TEC_CC_B_ROLE_BIT] && (cnt_q == reg_b_q); // [RULE_08]
   assign cap_a = running && ccctl_q[TEC_CC_A_ROLE_BIT]
      && (ccctl_q[TEC_CC_A_TRIG_BIT] ? e1_opposite : e2_valid); // [RULE_09]
   assign cap_b = running && ccctl_q[TEC_CC_B_ROLE_BIT] && e1_valid; // [RULE_08]
   assign restart = (mode_q == TEC_MODE_EDGE_CLR) && e1_valid; // [RULE_24]
   assign wrap = cnt_tick && (cnt_q == TEC_CNT_MAX);

   // mode register and stop/restart bookkeeping
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= TEC_MODE_STOP; // [RULE_01]
      end else if (wr && addr_is(bus_req_i, TEC_OFS_MODE)) begin
         mode_q <= tec_mode_t'(bus_req_i.wdata[TEC_MODE_HI_BIT:TEC_MODE_LO_BIT]); // [RULE_02]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ran_q <= 1'b0;
      end else if (ce_i && running) begin
         ran_q <= 1'b1;
      end
   end

   // overflow flag: hardware set wins over a software write
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ovf_q <= 1'b0; // [RULE_01]
      end else if (wrap) begin
         ovf_q <= 1'b1; // [RULE_05] [RULE_07]
      end else if (wr && addr_is(bus_req_i, TEC_OFS_MODE)) begin
         ovf_q <= bus_req_i.wdata[TEC_MODE_OVF_BIT]; // [RULE_05]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ccctl_q <= TEC_RST_CTRL[2:0]; // [RULE_01]
      end else if (wr && addr_is(bus_req_i, TEC_OFS_CCCTL)) begin
         ccctl_q <= bus_req_i.wdata[TEC_CC_B_ROLE_BIT:TEC_CC_A_ROLE_BIT];
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         inv_a_q <= 1'b0; // [RULE_01]
         inv_b_q <= 1'b0;
         gate_q <= 1'b0;
      end else if (wr && addr_is(bus_req_i, TEC_OFS_OUTCTL)) begin
         inv_a_q <= bus_req_i.wdata[TEC_OC_INV_A_BIT]; // [RULE_15]
         inv_b_q <= bus_req_i.wdata[TEC_OC_INV_B_BIT]; // [RULE_15]
         gate_q <= bus_req_i.wdata[TEC_OC_GATE_BIT]; // [RULE_17]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         e2_sel_q <= TEC_EDGE_FALL; // [RULE_01]
         e1_sel_q <= TEC_EDGE_FALL;
         src_q <= TEC_SRC_CLK1;
      end else if (wr && addr_is(bus_req_i, TEC_OFS_PRESC)) begin
         e2_sel_q <= tec_edge_t'(bus_req_i.wdata[TEC_PS_E2_HI_BIT:TEC_PS_E2_LO_BIT]); // [RULE_18]
         e1_sel_q <= tec_edge_t'(bus_req_i.wdata[TEC_PS_E1_HI_BIT:TEC_PS_E1_LO_BIT]); // [RULE_18]
         src_q <= tec_src_t'(bus_req_i.wdata[TEC_PS_CLK_HI_BIT:TEC_PS_CLK_LO_BIT]); // [RULE_19]
      end
   end

   // register A: software load, or capture of the count
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_a_q <= TEC_RST_CNT;
      end else if (cap_a) begin
         reg_a_q <= cnt_q; // [RULE_09] [RULE_10]
      end else if (wr && addr_is(bus_req_i, TEC_OFS_REGA_LO)) begin
         reg_a_q[7:0] <= bus_req_i.wdata;
      end else if (wr && addr_is(bus_req_i, TEC_OFS_REGA_HI)) begin
         reg_a_q[15:8] <= bus_req_i.wdata;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_b_q <= TEC_RST_CNT;
      end else if (cap_b) begin
         reg_b_q <= cnt_q; // [RULE_08]
      end else if (wr && addr_is(bus_req_i, TEC_OFS_REGB_LO)) begin
         reg_b_q[7:0] <= bus_req_i.wdata;
      end else if (wr && addr_is(bus_req_i, TEC_OFS_REGB_HI)) begin
         reg_b_q[15:8] <= bus_req_i.wdata;
      end
   end

   // up counter
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= TEC_RST_CNT;
      end else if (ce_i) begin
         if (!running) begin
            cnt_q <= TEC_RST_CNT; // [RULE_02] [RULE_03]
         end else if (restart) begin
            cnt_q <= TEC_RST_CNT; // [RULE_24]
         end else if (match_a && (mode_q == TEC_MODE_MATCH_CLR)) begin
            cnt_q <= TEC_RST_CNT; // [RULE_24] [RULE_07]
         end else if (cnt_tick) begin
            cnt_q <= cnt_q + 16'h0001; // [RULE_23]
         end
      end
   end

   // output flip-flop: software force first, then match toggles
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flip_q <= 1'b0;
      end else if (wr && addr_is(bus_req_i, TEC_OFS_OUTCTL)
                   && (bus_req_i.wdata[TEC_OC_SET_BIT] ^ bus_req_i.wdata[TEC_OC_CLEAR_BIT])) begin
         flip_q <= bus_req_i.wdata[TEC_OC_SET_BIT]; // [RULE_16]
      end else if (ce_i) begin
         flip_q <= flip_q ^ (match_a && inv_a_q) ^ (match_b && inv_b_q); // [RULE_04] [RULE_15]
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer_output_pin_o <= 1'b0;
      end else if (ce_i) begin
         timer_output_pin_o <= gate_q && flip_q; // [RULE_17]
      end
   end

   // interrupt requests: one-cycle pulses on match or capture
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         match_a_interrupt_o <= 1'b0;
         match_b_interrupt_o <= 1'b0;
      end else if (ce_i) begin
         match_a_interrupt_o <= match_a || cap_a; // [RULE_04]
         match_b_interrupt_o <= match_b || cap_b; // [RULE_04]
      end
   end

   // read port: data in the cycle after the strobe, zero otherwise
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_rdata_o <= 8'h00;
      end else if (ce_i) begin
         bus_rdata_o <= 8'h00;
         if (rd) begin
            unique case (bus_req_i.addr)
               TEC_OFS_MODE: bus_rdata_o <= {4'h0, mode_q, 1'b0, ovf_q}; // [RULE_05]
               TEC_OFS_PRESC: bus_rdata_o <= {e2_sel_q, e1_sel_q, 2'b00, src_q};
               TEC_OFS_CCCTL: bus_rdata_o <= {5'h00, ccctl_q};
               TEC_OFS_OUTCTL: bus_rdata_o <= {3'h0, inv_b_q, 2'b00, inv_a_q, gate_q}; // [RULE_16]
               TEC_OFS_REGA_LO: bus_rdata_o <= reg_a_q[7:0];
               TEC_OFS_REGA_HI: bus_rdata_o <= reg_a_q[15:8];
               TEC_OFS_REGB_LO: bus_rdata_o <= reg_b_q[7:0];
               TEC_OFS_REGB_HI: bus_rdata_o <= reg_b_q[15:8];
               TEC_OFS_CNT_LO: bus_rdata_o <= cnt_q[7:0];
               TEC_OFS_CNT_HI: bus_rdata_o <= cnt_q[15:8];
               default: bus_rdata_o <= 8'h00;
            endcase
         end
      end
   end
endmodule : tec_timer_ctrl

// ==== sim/tec_timer_ctrl_sva.sv ====
// checker: port-level properties of the timer control block
`timescale 1ns/1ps
module tec_timer_ctrl_sva
   import tec_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire tec_bus_req_t bus_req_i,
   input wire logic [7:0] bus_rdata_o,
   input wire logic timer_output_pin_o,
   input wire logic match_a_interrupt_o,
   input wire logic match_b_interrupt_o
);
   logic [15:0] ra;
   logic [15:0] wa;
   logic [1:0] mode_q;
   logic gate_q;
   logic [3:0] stop_q;
   logic stopped;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   // address of the access taken this cycle, zero when idle
   assign ra = (ce_i && bus_req_i.re) ? bus_req_i.addr : 16'h0000;
   assign wa = (ce_i && bus_req_i.we) ? bus_req_i.addr : 16'h0000;
   assign stopped = (stop_q == 4'hf);
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= 2'h0;
      end else if (wa == TEC_OFS_MODE) begin
         mode_q <= bus_req_i.wdata[3:2];
      end
   end
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_q <= 1'b0;
      end else if (wa == TEC_OFS_OUTCTL) begin
         gate_q <= bus_req_i.wdata[0];
      end
   end
   // stopped for four cycles, so no match from the last run is in flight
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_q <= 4'hf;
      end else begin
         stop_q <= {stop_q[2:0], mode_q == 2'h0};
      end
   end
   AST_RST_QUIET: assert property ($rose(rst_n_i) |-> !timer_output_pin_o
      && !match_a_interrupt_o && !match_b_interrupt_o) else $error("output active at reset");
   AST_MODE_READ: assert property ($past(ra) == TEC_OFS_MODE |->
      bus_rdata_o[7:4] == 4'h0 && !bus_rdata_o[1] && bus_rdata_o[3:2] == $past(mode_q))
      else $error("mode readback wrong");
   AST_CC_READ: assert property ($past(ra) == TEC_OFS_CCCTL |->
      bus_rdata_o[7:3] == 5'h00) else $error("capture control readback wrong");
   AST_OC_READ: assert property ($past(ra) == TEC_OFS_OUTCTL |->
      bus_rdata_o[7:5] == 3'h0 && bus_rdata_o[3:2] == 2'h0 && bus_rdata_o[0] == $past(gate_q))
      else $error("output control readback wrong");
   AST_GATE_LOW: assert property (!$past(gate_q) |-> !timer_output_pin_o)
      else $error("pin high while gated");
   AST_STOP_IRQ: assert property (stopped |->
      !match_a_interrupt_o && !match_b_interrupt_o) else $error("interrupt while stopped");
   AST_STOP_PIN: assert property (stopped && $past(wa) != TEC_OFS_OUTCTL
      && $past(wa, 2) != TEC_OFS_OUTCTL |-> $stable(timer_output_pin_o))
      else $error("pin moved while stopped");
   AST_FORCE_SET: assert property (wa == TEC_OFS_OUTCTL &&
      bus_req_i.wdata[4:0] == 5'h09 |-> ##2 timer_output_pin_o) else $error("force set lost");
   AST_CNT_STOP: assert property ($past(ra) == TEC_OFS_CNT_LO && $past(stopped) |->
      bus_rdata_o == 8'h00) else $error("counter not zero while stopped");
endmodule : tec_timer_ctrl_sva

// ==== sim/tec_pin_model.sv ====
// pin-side model: free-running subsystem clocks and width-limited edge input pulses
`timescale 1ns/1ps
module tec_pin_model #(
   parameter int MIN_HOLD = 40
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] lvl_i,
   output logic clk_one_o,
   output logic clk_two_o,
   output logic [1:0] pin_o
);
   int hold_q [2];
   initial begin
      clk_one_o = 1'b0;
      #5;
      forever #20 clk_one_o = ~clk_one_o;
   end
   initial begin
      clk_two_o = 1'b0;
      #2;
      forever #12 clk_two_o = ~clk_two_o;
   end
   // a level is kept long enough for the sampling filter to see it twice
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      for (int i = 0; i < 2; i++) begin
         if (!rst_n_i) begin
            pin_o[i] <= 1'b0;
            hold_q[i] <= 0;
         end else if (lvl_i[i] != pin_o[i] && hold_q[i] >= MIN_HOLD) begin
            pin_o[i] <= lvl_i[i];
            hold_q[i] <= 0;
         end else if (hold_q[i] < MIN_HOLD) begin
            hold_q[i] <= hold_q[i] + 1;
         end
      end
   end
endmodule : tec_pin_model

// ==== sim/tec_timer_ctrl_tb_top.sv ====
// testbench: register, counter, output and capture scenarios of the timer block
`timescale 1ns/1ps
module tec_timer_ctrl_tb_top
   import tec_pkg::*;
;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ce_i = 1'b1;
   tec_bus_req_t bus_req_i = '0;
   logic [7:0] bus_rdata_o;
   logic [1:0] lvl = 2'h0;
   logic [1:0] pin;
   logic clk_one;
   logic clk_two;
   logic pin_o;
   logic irq_a;
   logic irq_b;
   int errors = 0;
   int cmp_count = 0;
   int cnt_a = 0;
   int cnt_b = 0;
   int exp_n [4] = '{1, 1, 0, 2};
   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cnt_a <= cnt_a + int'(irq_a === 1'b1);
      cnt_b <= cnt_b + int'(irq_b === 1'b1);
   end
   tec_timer_ctrl tec_timer_ctrl_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
      .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o), .subsystem_clock_one_i(clk_one),
      .subsystem_clock_two_i(clk_two), .first_edge_input_i(pin[0]),
      .second_edge_input_i(pin[1]), .timer_output_pin_o(pin_o),
      .match_a_interrupt_o(irq_a), .match_b_interrupt_o(irq_b));
   tec_pin_model tec_pin_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .lvl_i(lvl),
      .clk_one_o(clk_one), .clk_two_o(clk_two), .pin_o(pin));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      bus_req_i.addr <= a;
      bus_req_i.wdata <= d;
      bus_req_i.we <= 1'b1;
      @(posedge mclk_i);
      bus_req_i.we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      bus_req_i.addr <= a;
      bus_req_i.re <= 1'b1;
      @(posedge mclk_i);
      bus_req_i.re <= 1'b0;
      #1;
      d = bus_rdata_o;
   endtask : rd
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      check(16'(d), 16'(e));
   endtask : rdc
   task automatic idle(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : idle
   task automatic t_reset_vals;
      rdc(TEC_OFS_MODE, 8'h00);
      rdc(TEC_OFS_PRESC, 8'h00);
      rdc(TEC_OFS_CCCTL, 8'h00);
      rdc(TEC_OFS_OUTCTL, 8'h00);
      rdc(16'hff6a, 8'h00);
      wr(TEC_OFS_MODE, 8'h01);
      rdc(TEC_OFS_MODE, 8'h01);
      wr(TEC_OFS_MODE, 8'h00);
   endtask : t_reset_vals
   task automatic t_match_restart;
      logic [7:0] d;
      logic p;
      int a0;
      int tog;
      wr(TEC_OFS_REGA_LO, 8'h09);
      wr(TEC_OFS_REGA_HI, 8'h00);
      wr(TEC_OFS_OUTCTL, 8'h13);
      wr(TEC_OFS_MODE, 8'h0c);
      rdc(TEC_OFS_MODE, 8'h0c);
      a0 = cnt_a;
      tog = 0;
      p = pin_o;
      repeat (1000) begin
         @(posedge mclk_i);
         tog += int'(pin_o !== p);
         p = pin_o;
      end
      check(16'(cnt_a - a0 inside {[19:21]}), 16'h0001);
      check(16'(tog inside {[39:41]}), 16'h0001);
      repeat (6) begin
         rd(TEC_OFS_CNT_LO, d);
         check(16'(d <= 8'h09), 16'h0001);
      end
      wr(TEC_OFS_MODE, 8'h00);
      idle(4);
      rdc(TEC_OFS_CNT_LO, 8'h00);
   endtask : t_match_restart
   task automatic t_force;
      wr(TEC_OFS_OUTCTL, 8'h09);
      idle(2);
      check(16'(pin_o), 16'h0001);
      rdc(TEC_OFS_OUTCTL, 8'h01);
      wr(TEC_OFS_OUTCTL, 8'h05);
      idle(2);
      check(16'(pin_o), 16'h0000);
      wr(TEC_OFS_OUTCTL, 8'h09);
      wr(TEC_OFS_OUTCTL, 8'h08);
      idle(2);
      check(16'(pin_o), 16'h0000);
   endtask : t_force
   task automatic run_src(input logic [7:0] ps, input int lo, input int hi);
      logic [7:0] d;
      wr(TEC_OFS_PRESC, ps);
      wr(TEC_OFS_MODE, 8'h04);
      repeat (6) begin
         idle(100);
         lvl <= ~lvl;
      end
      rd(TEC_OFS_CNT_LO, d);
      wr(TEC_OFS_MODE, 8'h00);
      check(16'(d >= lo && d <= hi), 16'h0001);
   endtask : run_src
   task automatic run_edges(input logic [7:0] cc, input logic [7:0] ps, input int ea,
         input int eb);
      int a0;
      int b0;
      wr(TEC_OFS_CCCTL, cc);
      wr(TEC_OFS_PRESC, ps);
      wr(TEC_OFS_MODE, 8'h04);
      a0 = cnt_a;
      b0 = cnt_b;
      idle(60);
      lvl <= 2'h3;
      idle(80);
      lvl <= 2'h0;
      idle(80);
      wr(TEC_OFS_MODE, 8'h00);
      check(16'(cnt_a - a0), 16'(ea));
      check(16'(cnt_b - b0), 16'(eb));
   endtask : run_edges
   task automatic t_restart;
      logic [7:0] d;
      int b0;
      wr(TEC_OFS_PRESC, 8'h10);
      wr(TEC_OFS_MODE, 8'h08);
      idle(60);
      lvl <= 2'h3;
      idle(30);
      ce_i <= 1'b0;
      idle(40);
      ce_i <= 1'b1;
      rd(TEC_OFS_CNT_LO, d);
      check(16'(d < 8'h0a), 16'h0001);
      wr(TEC_OFS_MODE, 8'h00);
      rst_n_i <= 1'b0;
      idle(2);
      rst_n_i <= 1'b1;
      idle(50);
      b0 = cnt_b;
      wr(TEC_OFS_CCCTL, 8'h04);
      wr(TEC_OFS_PRESC, 8'h10);
      wr(TEC_OFS_MODE, 8'h04);
      idle(20);
      check(16'(cnt_b - b0), 16'h0001);
   endtask : t_restart
   task automatic end_sim;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (12) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_reset_vals();
      t_match_restart();
      t_force();
      run_src(8'h00, 116, 122);
      run_src(8'h01, 57, 61);
      run_src(8'h02, 11, 13);
      run_src(8'h13, 3, 3);
      for (int c = 0; c < 4; c++) begin
         run_edges(8'h05, 8'(c * 8'h50), exp_n[c], exp_n[c]);
      end
      run_edges(8'h07, 8'h10, 1, 1);
      run_edges(8'h07, 8'h30, 0, 2);
      t_restart();
      end_sim();
   end
endmodule : tec_timer_ctrl_tb_top
bind tec_timer_ctrl tec_timer_ctrl_sva tec_timer_ctrl_sva_inst (.mclk_i(mclk_i),
   .rst_n_i(rst_n_i), .ce_i(ce_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o),
   .timer_output_pin_o(timer_output_pin_o), .match_a_interrupt_o(match_a_interrupt_o),
   .match_b_interrupt_o(match_b_interrupt_o));
